// *** verification/rcvcfg_regs_asserts.sv ***
// Port-level assertions for the receiver configuration register bank
`timescale 1ns/1ps
module rcvcfg_regs_asserts (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        set_default,
  input wire logic        very_high_bit_rate,
  input wire logic        active_p2p_preset,
  input wire logic        am_enable_ctl,
  input wire logic        pm_enable_ctl,
  input wire logic        single_ended,
  input wire logic        tx_end,
  input wire logic [7:0]  mask_time_code,
  input wire logic        am_channel_en,
  input wire logic        pm_channel_en,
  input wire logic        am_demod_mixer,
  input wire logic        pm_mixer_internal,
  input wire logic        stage_clip,
  input wire logic        forced_gain_reduction,
  input wire logic        rx_masked,
  input wire logic        squelch_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic        rd_take;
  logic [15:0] cnt_r;
  logic [15:0] len_r;
  logic [15:0] since_r;
  assign rd_take = hsel & hready & htrans[1] & ~hwrite;
  // A retrigger restarts both counts, as the mask does
  always_ff @(posedge clock) begin
    if (rst || tx_end) cnt_r <= 16'h0000;
    else if (rx_masked) cnt_r <= cnt_r + 16'h0001;
  end
  always_ff @(posedge clock) begin
    if (rst) len_r <= 16'h0000;
    else if (tx_end) len_r <= 16'h00ec *
      ((mask_time_code < 8'h04) ? 16'h0004 : {8'h00, mask_time_code});
  end
  always_ff @(posedge clock) begin
    if (rst || tx_end) since_r <= 16'h0000;
    else if (since_r != 16'hffff) since_r <= since_r + 16'h0001;
  end
  sequence s_very_high_bit_rate_held;
    !set_default && very_high_bit_rate ##1 very_high_bit_rate;
  endsequence
  sequence s_p2p_held;
    !set_default && active_p2p_preset ##1 active_p2p_preset;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_rdata_idle: assert property (!$past(rd_take) |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_pmix_single: assert property (!$past(rst) && single_ended |=> pm_mixer_internal)
    else $error("single ended mode without internal mixer clock");
  a_very_high_bit_rate_mixer: assert property (s_very_high_bit_rate_held |-> ##1 am_demod_mixer)
    else $error("high rate preset did not select mixer");
  a_p2p_preset: assert property (s_p2p_held |-> ##1 (stage_clip && forced_gain_reduction))
    else $error("active mode preset missing");
  a_one_channel: assert property (!$past(rst) && (am_enable_ctl ^ pm_enable_ctl)
    |=> am_channel_en ^ pm_channel_en)
    else $error("not exactly one channel enabled");
  a_mask_start: assert property (tx_end |=> rx_masked)
    else $error("mask not started after transmit end");
  a_mask_length: assert property ($fell(rx_masked) |-> cnt_r == len_r)
    else $error("mask length wrong");
  a_squelch_start: assert property ($rose(squelch_active)
    |-> since_r == 16'h03b0 || since_r == 16'h03b1)
    else $error("squelch started at wrong time");
  a_squelch_inside: assert property (squelch_active |-> rx_masked)
    else $error("squelch outside mask");
endmodule

// *** verification/rcvcfg_regs_test.sv ***
// Self-checking bench for the receiver configuration register bank
`timescale 1ns/1ps
module rcvcfg_regs_test;
  logic        clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        set_default = 1'b0, very_high_bit_rate = 1'b0, active_p2p_preset = 1'b0;
  logic        am_enable_ctl = 1'b1, pm_enable_ctl = 1'b0, manual_select = 1'b0;
  logic        single_ended = 1'b0, tx_end = 1'b0, hready, hreadyout, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, lowpass_code, am_first_gain, pm_first_gain;
  logic [7:0]  mask_time_code = 8'h00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic        am_channel_en, pm_channel_en, framing_from_pm, am_demod_mixer, zero_set_high;
  logic        zero_set_mid, zero_set_low, receiver_low_power, lf_input_split, lf_signal_enable;
  logic        agc_enable, agc_whole_period, agc_reset_alg, pm_mixer_internal, stage_clip;
  logic        forced_gain_reduction, rx_masked, squelch_active;
  logic [7:0]  idx [3] = '{rcvcfg_pkg::RCVCFG_IDX_ONE, rcvcfg_pkg::RCVCFG_IDX_TWO,
                           rcvcfg_pkg::RCVCFG_IDX_THREE};
  logic [7:0]  dflt [3] = '{rcvcfg_pkg::RCVCFG_RST_ONE, rcvcfg_pkg::RCVCFG_RST_TWO,
                            rcvcfg_pkg::RCVCFG_RST_THREE};
  // Channel-select and squelch-enable bits have no output of their own
  logic [7:0]  msk [3] = '{8'h7f, 8'hfd, 8'hff};
  int          error_cnt = 0, checked = 0, cyc = 0;
  assign hready = hreadyout;
  always #10 clock = ~clock;
  rcvcfg_regs dut (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .set_default, .very_high_bit_rate, .active_p2p_preset,
    .am_enable_ctl, .pm_enable_ctl, .manual_select, .single_ended, .tx_end, .mask_time_code,
    .am_channel_en, .pm_channel_en, .framing_from_pm, .am_demod_mixer, .lowpass_code,
    .zero_set_high, .zero_set_mid, .zero_set_low, .receiver_low_power, .lf_input_split,
    .lf_signal_enable, .agc_enable, .agc_whole_period, .agc_reset_alg, .pm_mixer_internal,
    .am_first_gain, .pm_first_gain, .stage_clip, .forced_gain_reduction, .rx_masked,
    .squelch_active);
  function automatic logic [7:0] obs(input int i);
    if (i == 0) return {1'b0, am_demod_mixer, lowpass_code, zero_set_high, zero_set_mid,
                        zero_set_low};
    if (i == 1) return {receiver_low_power, lf_input_split, lf_signal_enable, agc_enable,
                        agc_whole_period, agc_reset_alg, 1'b0, pm_mixer_internal};
    return {am_first_gain, pm_first_gain, stage_clip, forced_gain_reduction};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, a, 2'h0};
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk("read data", r, {24'h0, e});
  endtask
  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      chk("outputs after reset", obs(i), dflt[i] & msk[i]);
      rd(idx[i], dflt[i]);
    end
    rd(8'h0d, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_fields();
    logic [7:0] pat [2] = '{8'ha5, 8'h5a};
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 2; j++) begin
        wr(idx[i], pat[j]);
        repeat (2) @(posedge clock);
        chk("field outputs", obs(i), pat[j] & msk[i]);
        rd(idx[i], pat[j]);
      end
    end
    $display("test fields done");
  endtask
  task automatic t_chan();
    for (int s = 0; s < 2; s++) begin
      wr(idx[0], {s[0], 7'h00});
      pm_enable_ctl <= 1'b0;
      repeat (3) @(posedge clock);
      chk("channel enables", {am_channel_en, pm_channel_en}, {~s[0], s[0]});
      pm_enable_ctl <= 1'b1;
      manual_select <= 1'b1;
      single_ended <= 1'b1;
      repeat (3) @(posedge clock);
      chk("framing source", framing_from_pm, s[0]);
      chk("pm mixer clock", pm_mixer_internal, 1'b1);
      single_ended <= 1'b0;
    end
    $display("test channels done");
  endtask
  task automatic t_default();
    set_default <= 1'b1;
    @(posedge clock);
    set_default <= 1'b0;
    for (int i = 0; i < 3; i++) rd(idx[i], dflt[i]);
    very_high_bit_rate <= 1'b1;
    active_p2p_preset <= 1'b1;
    wr(idx[0], 8'h00);
    rd(idx[0], 8'h40);
    rd(idx[2], dflt[2] | 8'h03);
    very_high_bit_rate <= 1'b0;
    active_p2p_preset <= 1'b0;
    $display("test defaults done");
  endtask
  task automatic t_mask(input logic [7:0] c, input int n, input logic sq);
    int len;
    logic saw;
    len = 0;
    saw = 1'b0;
    mask_time_code <= c;
    tx_end <= 1'b1;
    @(posedge clock);
    tx_end <= 1'b0;
    repeat (2100) begin
      @(posedge clock);
      if (rx_masked === 1'b1) len++;
      if (squelch_active === 1'b1) saw = 1'b1;
    end
    chk("mask length", len, n * 236);
    chk("squelch seen", saw, sq);
    $display("test mask done");
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_reset();
    t_fields();
    t_chan();
    t_default();
    t_mask(8'h08, 8, 1'b1);
    t_mask(8'h02, 4, 1'b0);
    wr(idx[1], 8'h18);
    t_mask(8'h08, 8, 1'b0);
    results();
  end
  // Ceiling well above the roughly 6400 cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
endmodule
bind rcvcfg_regs rcvcfg_regs_asserts chk_i (.clock, .rst, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .set_default, .very_high_bit_rate, .active_p2p_preset,
  .am_enable_ctl, .pm_enable_ctl, .single_ended, .tx_end, .mask_time_code, .am_channel_en,
  .pm_channel_en, .am_demod_mixer, .pm_mixer_internal, .stage_clip, .forced_gain_reduction,
  .rx_masked, .squelch_active);

// *** verilog/rcvcfg_pkg.sv ***
// Constants for the receiver configuration register bank
// Function
// - With one channel enabled, channel select picks AM (0) or PM (1).
// - Both channels and manual select: channel select picks the framing source.
// - AM demodulator bit: 0 peak detector, 1 mixer; preset to mixer for high rate.
// - Three low-pass code bits go straight to the receiver filter.
// - Three zero-setting bits go straight to the filter, each on its own.
// - Power-up and set-default command load every bit with its default.
// - Low-power bit set gives low-power receiver, clear gives normal operation.
// - Split bit 0 differential input; 1 input one to AM, two to PM.
// - LF enable bit routes the LF signal onto the receiver input.
// - Gain control enable bit, and mode: first eight pulses or whole receive.
// - Gain algorithm bit: 0 preset algorithm, 1 reset algorithm.
// - Auto squelch starts 18.88 us after transmit end, stops at mask expiry.
// - PM mixer clock: 0 transmitter output, 1 internal; single-ended forces internal.
// - AM first-stage gain code: 0 full, 1-6 steps down, 7 boost.
// - PM first-stage gain code uses the same coding as the AM field.
// - Clip bit limits first and second stage outputs; preset for active mode.
// - Forced gain reduction bit; preset for active peer-to-peer mode.
// - Mask timer counts 64/fc steps from transmit end; receiver masked meanwhile.
package rcvcfg_pkg;
  localparam logic [7:0] RCVCFG_IDX_ONE   = 8'h0a;
  localparam logic [7:0] RCVCFG_IDX_TWO   = 8'h0b;
  localparam logic [7:0] RCVCFG_IDX_THREE = 8'h0c;
  localparam logic [7:0] RCVCFG_RST_ONE   = 8'h00;
  localparam logic [7:0] RCVCFG_RST_TWO   = 8'h1a;
  localparam logic [7:0] RCVCFG_RST_THREE = 8'hd8;
  // Field positions, register one
  localparam int RCVCFG_CHANNEL_SELECT   = 7;
  localparam int RCVCFG_AMD_SEL  = 6;
  localparam int RCVCFG_LP_HI    = 5;
  localparam int RCVCFG_LP_LO    = 3;
  localparam int RCVCFG_ZERO_HI  = 2;
  localparam int RCVCFG_ZERO_MID = 1;
  localparam int RCVCFG_ZERO_LO  = 0;
  // Field positions, register two
  localparam int RCVCFG_LOW_PWR  = 7;
  localparam int RCVCFG_LF_SPLIT = 6;
  localparam int RCVCFG_LF_SIGNAL_ENABLE    = 5;
  localparam int RCVCFG_AGC_EN   = 4;
  localparam int RCVCFG_AGC_MODE = 3;
  localparam int RCVCFG_AGC_ALG  = 2;
  localparam int RCVCFG_SQ_AUTO  = 1;
  localparam int RCVCFG_PMIX     = 0;
  // Field positions, register three
  localparam int RCVCFG_AM_G_HI  = 7;
  localparam int RCVCFG_AM_G_LO  = 5;
  localparam int RCVCFG_PM_G_HI  = 4;
  localparam int RCVCFG_PM_G_LO  = 2;
  localparam int RCVCFG_CLIP     = 1;
  localparam int RCVCFG_FGR      = 0;
  // Timing
  localparam int     RCVCFG_CLK_KHZ     = 50000;
  localparam int     RCVCFG_SQ_DELAY_NS = 18880;
  localparam int     RCVCFG_SQ_CYC      = (RCVCFG_SQ_DELAY_NS * RCVCFG_CLK_KHZ
                                           + 999999) / 1000000;
  localparam int     RCVCFG_FC_KHZ      = 13560;
  localparam int     RCVCFG_MASK_FC     = 64;
  localparam int     RCVCFG_STEP_CYC    = (RCVCFG_MASK_FC * RCVCFG_CLK_KHZ
                                           + RCVCFG_FC_KHZ - 1) / RCVCFG_FC_KHZ;
  localparam logic [7:0] RCVCFG_MASK_MIN = 8'h04;
endpackage

// *** verilog/rcvcfg_regs.sv ***
// Receiver configuration register bank with AHB-Lite slave
`timescale 1ns/1ps
module rcvcfg_regs (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        set_default,
  input  wire logic        very_high_bit_rate,
  input  wire logic        active_p2p_preset,
  input  wire logic        am_enable_ctl,
  input  wire logic        pm_enable_ctl,
  input  wire logic        manual_select,
  input  wire logic        single_ended,
  input  wire logic        tx_end,
  input  wire logic [7:0]  mask_time_code,
  output logic             am_channel_en,
  output logic             pm_channel_en,
  output logic             framing_from_pm,
  output logic             am_demod_mixer,
  output logic [2:0]       lowpass_code,
  output logic             zero_set_high,
  output logic             zero_set_mid,
  output logic             zero_set_low,
  output logic             receiver_low_power,
  output logic             lf_input_split,
  output logic             lf_signal_enable,
  output logic             agc_enable,
  output logic             agc_whole_period,
  output logic             agc_reset_alg,
  output logic             pm_mixer_internal,
  output logic [2:0]       am_first_gain,
  output logic [2:0]       pm_first_gain,
  output logic             stage_clip,
  output logic             forced_gain_reduction,
  output logic             rx_masked,
  output logic             squelch_active
);

  logic [7:0]  cfg_one_r;
  logic [7:0]  cfg_two_r;
  logic [7:0]  cfg_three_r;
  logic        wr_pend_r;
  logic [7:0]  wr_idx_r;
  logic [15:0] sq_cnt_r;
  logic        sq_wait_r;
  logic [15:0] step_cnt_r;
  logic [7:0]  mask_left_r;
  logic        mask_run_r;
  logic        mask_expire;
  logic        addr_ok;
  logic [7:0]  addr_idx;
  logic        wr_one;
  logic        wr_two;
  logic        wr_three;

  // Register index from a word-aligned byte address
  function automatic logic [7:0] word_index(input logic [31:0] a);
    return a[9:2];
  endfunction

  function automatic logic [7:0] read_mux(input logic [7:0] idx,
                                         input logic [7:0] r1,
                                         input logic [7:0] r2,
                                         input logic [7:0] r3);
    logic [7:0] v;
    v = 8'h00;
    if (idx == rcvcfg_pkg::RCVCFG_IDX_ONE) begin
      v = r1;
    end else if (idx == rcvcfg_pkg::RCVCFG_IDX_TWO) begin
      v = r2;
    end else if (idx == rcvcfg_pkg::RCVCFG_IDX_THREE) begin
      v = r3;
    end
    return v;
  endfunction

  assign addr_idx = word_index(haddr);
  assign addr_ok  = hsel && hready && htrans[1] && (haddr[31:10] == 22'h000000);
  assign wr_one   = wr_pend_r && (wr_idx_r == rcvcfg_pkg::RCVCFG_IDX_ONE);
  assign wr_two   = wr_pend_r && (wr_idx_r == rcvcfg_pkg::RCVCFG_IDX_TWO);
  assign wr_three = wr_pend_r && (wr_idx_r == rcvcfg_pkg::RCVCFG_IDX_THREE);

  // Zero wait states, always OKAY
  always_ff @(posedge clock) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Write address captured in the address phase, data used in the data phase
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      wr_idx_r  <= addr_idx;
    end
  end

  // Read data prepared at the address phase; unmapped words read zero
  always_ff @(posedge clock) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= {24'h000000,
                 read_mux(addr_idx, cfg_one_r, cfg_two_r, cfg_three_r)};
    end else begin
      hrdata <= 32'h00000000;
    end
  end

  // Defaults win over writes; hardware presets win over a same-cycle write
  always_ff @(posedge clock) begin
    if (rst || set_default) begin
      cfg_one_r <= rcvcfg_pkg::RCVCFG_RST_ONE;
    end else begin
      if (wr_one) begin
        cfg_one_r <= hwdata[7:0];
      end
      if (very_high_bit_rate) begin
        cfg_one_r[rcvcfg_pkg::RCVCFG_AMD_SEL] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst || set_default) begin
      cfg_two_r <= rcvcfg_pkg::RCVCFG_RST_TWO;
    end else if (wr_two) begin
      cfg_two_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst || set_default) begin
      cfg_three_r <= rcvcfg_pkg::RCVCFG_RST_THREE;
    end else begin
      if (wr_three) begin
        cfg_three_r <= hwdata[7:0];
      end
      if (active_p2p_preset) begin
        cfg_three_r[rcvcfg_pkg::RCVCFG_CLIP] <= 1'b1;
        cfg_three_r[rcvcfg_pkg::RCVCFG_FGR]  <= 1'b1;
      end
    end
  end

  // Channel enables and framing source
  always_ff @(posedge clock) begin
    if (rst) begin
      am_channel_en   <= 1'b0;
      pm_channel_en   <= 1'b0;
      framing_from_pm <= 1'b0;
    end else if (am_enable_ctl && pm_enable_ctl) begin
      am_channel_en   <= 1'b1;
      pm_channel_en   <= 1'b1;
      // Automatic selection lives outside; hold AM as the neutral choice
      framing_from_pm <= manual_select && cfg_one_r[rcvcfg_pkg::RCVCFG_CHANNEL_SELECT];
    end else if (am_enable_ctl || pm_enable_ctl) begin
      am_channel_en   <= !cfg_one_r[rcvcfg_pkg::RCVCFG_CHANNEL_SELECT];
      pm_channel_en   <= cfg_one_r[rcvcfg_pkg::RCVCFG_CHANNEL_SELECT];
      framing_from_pm <= cfg_one_r[rcvcfg_pkg::RCVCFG_CHANNEL_SELECT];
    end else begin
      am_channel_en   <= 1'b0;
      pm_channel_en   <= 1'b0;
      framing_from_pm <= 1'b0;
    end
  end

  // Register one fields to the demodulator and filter
  always_ff @(posedge clock) begin
    if (rst) begin
      am_demod_mixer <= 1'b0;
      lowpass_code   <= 3'h0;
      zero_set_high  <= 1'b0;
      zero_set_mid   <= 1'b0;
      zero_set_low   <= 1'b0;
    end else begin
      am_demod_mixer <= cfg_one_r[rcvcfg_pkg::RCVCFG_AMD_SEL];
      lowpass_code   <= cfg_one_r[rcvcfg_pkg::RCVCFG_LP_HI:rcvcfg_pkg::RCVCFG_LP_LO];
      zero_set_high  <= cfg_one_r[rcvcfg_pkg::RCVCFG_ZERO_HI];
      zero_set_mid   <= cfg_one_r[rcvcfg_pkg::RCVCFG_ZERO_MID];
      zero_set_low   <= cfg_one_r[rcvcfg_pkg::RCVCFG_ZERO_LO];
    end
  end

  // Register two fields
  always_ff @(posedge clock) begin
    if (rst) begin
      receiver_low_power <= 1'b0;
      lf_input_split     <= 1'b0;
      lf_signal_enable   <= 1'b0;
      agc_enable         <= 1'b0;
      agc_whole_period   <= 1'b0;
      agc_reset_alg      <= 1'b0;
      pm_mixer_internal  <= 1'b0;
    end else begin
      receiver_low_power <= cfg_two_r[rcvcfg_pkg::RCVCFG_LOW_PWR];
      lf_input_split     <= cfg_two_r[rcvcfg_pkg::RCVCFG_LF_SPLIT];
      lf_signal_enable   <= cfg_two_r[rcvcfg_pkg::RCVCFG_LF_SIGNAL_ENABLE];
      agc_enable         <= cfg_two_r[rcvcfg_pkg::RCVCFG_AGC_EN];
      agc_whole_period   <= cfg_two_r[rcvcfg_pkg::RCVCFG_AGC_MODE];
      agc_reset_alg      <= cfg_two_r[rcvcfg_pkg::RCVCFG_AGC_ALG];
      pm_mixer_internal  <= cfg_two_r[rcvcfg_pkg::RCVCFG_PMIX] || single_ended;
    end
  end

  // Register three fields; gain change after clearing reduction needs a receiver restart
  always_ff @(posedge clock) begin
    if (rst) begin
      am_first_gain         <= 3'h0;
      pm_first_gain         <= 3'h0;
      stage_clip            <= 1'b0;
      forced_gain_reduction <= 1'b0;
    end else begin
      am_first_gain <= cfg_three_r[rcvcfg_pkg::RCVCFG_AM_G_HI:rcvcfg_pkg::RCVCFG_AM_G_LO];
      pm_first_gain <= cfg_three_r[rcvcfg_pkg::RCVCFG_PM_G_HI:rcvcfg_pkg::RCVCFG_PM_G_LO];
      stage_clip            <= cfg_three_r[rcvcfg_pkg::RCVCFG_CLIP];
      forced_gain_reduction <= cfg_three_r[rcvcfg_pkg::RCVCFG_FGR];
    end
  end

  // Mask timer: codes below the minimum still give the shortest mask
  assign mask_expire = mask_run_r && (mask_left_r == 8'h01) &&
                       (step_cnt_r == 16'(rcvcfg_pkg::RCVCFG_STEP_CYC - 1));

  always_ff @(posedge clock) begin
    if (rst) begin
      mask_run_r  <= 1'b0;
      mask_left_r <= 8'h00;
      step_cnt_r  <= 16'h0000;
      rx_masked   <= 1'b0;
    end else if (tx_end) begin
      mask_run_r  <= 1'b1;
      mask_left_r <= (mask_time_code < rcvcfg_pkg::RCVCFG_MASK_MIN) ?
                     rcvcfg_pkg::RCVCFG_MASK_MIN : mask_time_code;
      step_cnt_r  <= 16'h0000;
      rx_masked   <= 1'b1;
    end else if (mask_run_r) begin
      if (step_cnt_r == 16'(rcvcfg_pkg::RCVCFG_STEP_CYC - 1)) begin
        step_cnt_r  <= 16'h0000;
        mask_left_r <= mask_left_r - 8'h01;
        if (mask_left_r == 8'h01) begin
          mask_run_r <= 1'b0;
          rx_masked  <= 1'b0;
        end
      end else begin
        step_cnt_r <= step_cnt_r + 16'h0001;
      end
    end
  end

  // Squelch: delayed start after transmit end, stop at mask expiry
  always_ff @(posedge clock) begin
    if (rst) begin
      sq_wait_r      <= 1'b0;
      sq_cnt_r       <= 16'h0000;
      squelch_active <= 1'b0;
    end else if (tx_end) begin
      sq_wait_r      <= cfg_two_r[rcvcfg_pkg::RCVCFG_SQ_AUTO];
      sq_cnt_r       <= 16'h0000;
      squelch_active <= 1'b0;
    end else if (mask_expire) begin
      sq_wait_r      <= 1'b0;
      squelch_active <= 1'b0;
    end else if (sq_wait_r) begin
      if (sq_cnt_r == 16'(rcvcfg_pkg::RCVCFG_SQ_CYC - 1)) begin
        sq_wait_r      <= 1'b0;
        squelch_active <= 1'b1;
      end else begin
        sq_cnt_r <= sq_cnt_r + 16'h0001;
      end
    end
  end

endmodule
